// file: pkg/acs_map.svh
// Constants of the converter init and conversion sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_NUM_SLOT 8
`define ACS_IDX_W 3
`define ACS_BYTE_W 8
`define ACS_WORD_W 16
`define ACS_ADDR_W 23
`define ACS_FIFO_DEPTH 16
`define ACS_DIR_SEND 1'b0
`define ACS_DIR_RECV 1'b1
`define ACS_PTR_STEP 23'h000001
`define ACS_IDLE_BYTE 8'h00
`endif

// file: pkg/acs_pkg.sv
// Types of the converter init and conversion sequencer
`include "acs_map.svh"
package acs_pkg;
	typedef enum logic [9:0] {
		acs_st_idle = 10'h001,
		acs_st_send_index = 10'h002,
		acs_st_wait_index = 10'h004,
		acs_st_send_value = 10'h008,
		acs_st_wait_value = 10'h010,
		acs_st_send_cmd = 10'h020,
		acs_st_await_cmd_sent = 10'h040,
		acs_st_start_capture = 10'h080,
		acs_st_store = 10'h100,
		acs_st_done = 10'h200
	} acs_seq_state_type;
	typedef enum logic [2:0] {
		acs_ln_idle = 3'h1,
		acs_ln_arm = 3'h2,
		acs_ln_busy = 3'h4
	} acs_link_state_type;
	typedef struct packed {
		acs_seq_state_type st;
		logic [`ACS_NUM_SLOT-1:0] reg_pend;
		logic [`ACS_IDX_W-1:0] reg_sel;
		logic [`ACS_NUM_SLOT-1:0] chan_pend;
		logic [`ACS_IDX_W-1:0] chan_sel;
		logic fresh;
		logic have;
		logic [`ACS_ADDR_W-1:0] ptr;
		logic req_tog;
		logic [`ACS_BYTE_W-1:0] req_byte;
		logic req_dir;
		logic req_last;
		logic [2:0] ack_sync;
		logic ack_seen;
		logic push;
		logic [`ACS_ADDR_W+`ACS_WORD_W-1:0] push_data;
		logic sram_we;
		logic [`ACS_ADDR_W-1:0] sram_addr;
		logic [`ACS_WORD_W-1:0] sram_data;
		logic busy;
		logic done;
	} acs_sys_type;
	typedef struct packed {
		acs_link_state_type st;
		logic [2:0] req_sync;
		logic req_seen;
		logic go;
		logic dir;
		logic last;
		logic [`ACS_BYTE_W-1:0] tx;
		logic cs_n;
		logic ack_tog;
		logic [`ACS_WORD_W-1:0] rx;
	} acs_link_type;
endpackage

// file: testbench/acs_seq_properties.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_seq_properties (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_link,
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic sram_we,
	input wire logic [`ACS_ADDR_W-1:0] sram_addr,
	input wire logic [`ACS_WORD_W-1:0] sram_data,
	input wire logic sram_ready,
	input wire logic shift_go,
	input wire logic shift_dir,
	input wire logic [`ACS_BYTE_W-1:0] shift_tx,
	input wire logic shift_done,
	input wire logic adc_cs_n
);
	sequence s_go_rise;
		$rose(shift_go);
	endsequence
	sequence s_recv_end;
		shift_go && shift_done && shift_dir;
	endsequence
	a_busy_start: assert property (@(posedge clk_sys) disable iff (!nrst)
		!busy && !done && start |=> busy) else $error("busy missing");
	a_done_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
		done |=> done && !busy) else $error("done dropped");
	a_store_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
		sram_we && !sram_ready |=> sram_we && $stable({sram_addr, sram_data}))
		else $error("store moved");
	a_go_fresh: assert property (@(posedge clk_link) disable iff (!nrst)
		s_go_rise |-> !$past(shift_done) && !adc_cs_n) else $error("bad go");
	a_go_falls: assert property (@(posedge clk_link) disable iff (!nrst)
		shift_go && shift_done |=> !shift_go) else $error("go stuck");
	a_req_stable: assert property (@(posedge clk_link) disable iff (!nrst)
		shift_go && $past(shift_go) |-> $stable({shift_tx, shift_dir}))
		else $error("request moved");
	a_cs_after_recv: assert property (@(posedge clk_link) disable iff (!nrst)
		s_recv_end |=> adc_cs_n) else $error("select stays low");
	a_done_quiet: assert property (@(posedge clk_link) disable iff (!nrst)
		done |-> !$rose(shift_go)) else $error("shift after done");
	a_cs_during_go: assert property (@(posedge clk_link) disable iff (!nrst)
		shift_go |-> !adc_cs_n) else $error("select high in transfer");
endmodule // acs_seq_properties
bind acs_sequencer acs_seq_properties chk_u (.clk_sys, .nrst, .clk_link,
	.start, .busy, .done, .sram_we, .sram_addr, .sram_data, .sram_ready,
	.shift_go, .shift_dir, .shift_tx, .shift_done, .adc_cs_n);
`default_nettype wire

// file: testbench/acs_shift_model.sv
// Behavioural serial shifter that answers the link
`timescale 1ns/1ps
`default_nettype none
module acs_shift_model (
	input wire logic clk_link,
	input wire logic nrst,
	input wire logic slow,
	input wire logic shift_go,
	input wire logic shift_dir,
	input wire logic [7:0] shift_tx,
	output logic [15:0] shift_rx,
	output logic shift_done
);
	logic [8:0] sent[$];
	logic go_d;
	logic [3:0] cnt;
	logic [11:0] w;
	always @(posedge clk_link or negedge nrst) begin
		if (!nrst) begin
			go_d <= 1'b0;
			cnt <= 4'h0;
			w <= 12'h000;
			shift_done <= 1'b0;
			shift_rx <= 16'h0000;
			sent.delete();
		end else begin
			go_d <= shift_go;
			if (shift_go && !go_d) begin
				cnt <= slow ? 4'h9 : 4'h1;
				sent.push_back(shift_dir ? 9'h100 : {1'b0, shift_tx});
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
				shift_done <= (cnt == 4'h1);
				if (cnt == 4'h1 && shift_dir) begin
					shift_rx <= {w, 4'h0};
					w <= w + 12'h001;
				end
			end else if (!shift_go && shift_done) begin
				shift_done <= 1'b0;
				// Released line: never leave the last word showing
				shift_rx <= ~shift_rx;
			end
		end
	end
endmodule // acs_shift_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	typedef struct packed {
		logic [7:0] reg_en;
		logic [7:0] ch_en;
		logic [7:0] cnt;
		logic [7:0] words;
		logic slow;
		logic stall;
	} acs_row_type;
	// Stall row overfills the 16-word FIFO so capture must wait
	acs_row_type rows [4] = '{
		'{8'hff, 8'h81, 8'h03, 8'h06, 1'b0, 1'b0},
		'{8'h00, 8'h24, 8'h01, 8'h02, 1'b1, 1'b0},
		'{8'h05, 8'h00, 8'h01, 8'h00, 1'b0, 1'b0},
		'{8'h00, 8'h01, 8'h14, 8'h14, 1'b0, 1'b1}};
	logic clk_sys, clk_link, nrst, start, sram_ready, slow, busy, done;
	logic sram_we, shift_go, shift_dir, shift_done, adc_cs_n;
	logic [7:0] reg_wr_en, chan_en, shift_tx;
	logic [7:0][7:0] reg_index, reg_value, chan_cmd;
	logic [7:0][22:0] chan_base, chan_high;
	logic [22:0] sram_addr;
	logic [15:0] sram_data, shift_rx;
	logic [8:0] exp_b[$];
	logic [38:0] exp_w[$], got[$];
	int n_fail = 0;
	int checked = 0;
	acs_sequencer dut_u (.clk_sys, .nrst, .clk_link, .start, .reg_wr_en,
		.reg_index, .reg_value, .chan_en, .chan_cmd, .chan_base, .chan_high,
		.busy, .done, .sram_we, .sram_addr, .sram_data, .sram_ready,
		.shift_go, .shift_dir, .shift_tx, .shift_rx, .shift_done, .adc_cs_n);
	acs_shift_model m_u (.clk_link, .nrst, .slow, .shift_go, .shift_dir,
		.shift_tx, .shift_rx, .shift_done);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#37;
		forever #80 clk_link = ~clk_link;
	end
	always @(posedge clk_sys)
		if (sram_we === 1'b1 && sram_ready === 1'b1)
			got.push_back({sram_addr, sram_data});
	task stop_test;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task run_row(input int r);
		int n;
		nrst = 1'b0;
		start = 1'b0;
		slow = rows[r].slow;
		sram_ready = !rows[r].stall;
		reg_wr_en = rows[r].reg_en;
		chan_en = rows[r].ch_en;
		exp_b.delete();
		exp_w.delete();
		got.delete();
		n = 0;
		for (int i = 0; i < 8; i++) begin
			chan_high[i] = chan_base[i] + 23'(rows[r].cnt) - 23'h000001;
			if (reg_wr_en[i]) begin
				exp_b.push_back({1'b0, reg_index[i]});
				exp_b.push_back({1'b0, reg_value[i]});
			end
		end
		for (int c = 0; c < 8; c++)
			for (int k = 0; k < rows[r].cnt; k++) if (chan_en[c]) begin
				exp_b.push_back({1'b0, chan_cmd[c]});
				exp_b.push_back(9'h100);
				exp_w.push_back({chan_base[c] + 23'(k), n[11:0], 4'h0});
				n++;
			end
		cyc(40);
		nrst = 1'b1;
		cyc(40);
		start = 1'b1;
		for (n = 0; n < 30000 && done !== 1'b1; n++) begin
			cyc(1);
			if (n > 8000)
				sram_ready = 1'b1;
		end
		cyc(300);
		`CHK(done, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(m_u.sent.size(), exp_b.size())
		`CHK(got.size(), exp_w.size())
		`CHK(got.size(), int'(rows[r].words))
		foreach (exp_b[i]) `CHK(m_u.sent[i], exp_b[i])
		foreach (exp_w[i]) `CHK(got[i], exp_w[i])
		$display("test %0d done", r);
	endtask
	initial begin
		nrst = 1'b0;
		start = 1'b0;
		sram_ready = 1'b0;
		slow = 1'b0;
		reg_wr_en = 8'h00;
		chan_en = 8'h00;
		for (int i = 0; i < 8; i++) begin
			reg_index[i] = 8'h10 + 8'(i);
			reg_value[i] = 8'h20 + 8'(i);
			chan_cmd[i] = 8'h88 + 8'(i);
			chan_base[i] = 23'(i) << 8;
			chan_high[i] = chan_base[i];
		end
		cyc(6);
		nrst = 1'b1;
		for (int r = 0; r < 4; r++)
			run_row(r);
		nrst = 1'b0;
		cyc(40);
		nrst = 1'b1;
		reg_wr_en = 8'hff;
		cyc(1500);
		// Reset lands in mid sequence
		nrst = 1'b0;
		cyc(1);
		`CHK({busy, done, sram_we, shift_go, adc_cs_n}, 5'h01)
		start = 1'b0;
		cyc(39);
		nrst = 1'b1;
		cyc(400);
		`CHK(busy, 1'b0)
		`CHK(m_u.sent.size(), 0)
		$display("test reset done");
		stop_test;
	end
	initial begin
		#900000;
		n_fail++;
		stop_test;
	end
endmodule // tb_top
`default_nettype wire

// file: verilog/acs_fifo.sv
// Result FIFO between capture and the SRAM write port
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} acs_fifo_ptr_type;
	acs_fifo_ptr_type s;
	acs_fifo_ptr_type next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_wr;
	logic do_rd;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("acs_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	// Full when the pointers differ only in the wrap bit
	assign in_ready = !((s.wr[AW] != s.rd[AW]) &&
		(s.wr[AW-1:0] == s.rd[AW-1:0]));
	assign out_valid = (s.wr != s.rd);
	assign out_data = mem[s.rd[AW-1:0]];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (do_wr) begin
			next_s.wr = s.wr + 1'b1;
		end
		if (do_rd) begin
			next_s.rd = s.rd + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (do_wr) begin
			mem[s.wr[AW-1:0]] <= in_data;
		end
	end
endmodule // acs_fifo
`default_nettype wire

// file: verilog/acs_sequencer.sv
// Converter init and conversion sequencer with its shifter-facing link side
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int NUM_SLOT = `ACS_NUM_SLOT,
	parameter int FIFO_DEPTH = `ACS_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_link,
	// Sequence control and per-slot configuration tables
	input wire logic start,
	input wire logic [NUM_SLOT-1:0] reg_wr_en,
	input wire logic [NUM_SLOT-1:0][`ACS_BYTE_W-1:0] reg_index,
	input wire logic [NUM_SLOT-1:0][`ACS_BYTE_W-1:0] reg_value,
	input wire logic [NUM_SLOT-1:0] chan_en,
	input wire logic [NUM_SLOT-1:0][`ACS_BYTE_W-1:0] chan_cmd,
	input wire logic [NUM_SLOT-1:0][`ACS_ADDR_W-1:0] chan_base,
	input wire logic [NUM_SLOT-1:0][`ACS_ADDR_W-1:0] chan_high,
	// Status and SRAM write port
	output logic busy,
	output logic done,
	output logic sram_we,
	output logic [`ACS_ADDR_W-1:0] sram_addr,
	output logic [`ACS_WORD_W-1:0] sram_data,
	input wire logic sram_ready,
	// Shifter link, clocked by clk_link
	output logic shift_go,
	output logic shift_dir,
	output logic [`ACS_BYTE_W-1:0] shift_tx,
	input wire logic [`ACS_WORD_W-1:0] shift_rx,
	input wire logic shift_done,
	output logic adc_cs_n
);
	localparam int PW = `ACS_ADDR_W + `ACS_WORD_W;
	localparam acs_sys_type SYS_RST = '{st: acs_st_idle, default: '0};
	localparam acs_link_type LINK_RST =
		'{st: acs_ln_idle, cs_n: 1'b1, default: '0};

	acs_sys_type s;
	acs_sys_type next_s;
	acs_link_type l;
	acs_link_type next_l;
	logic ack_new;
	logic req_new;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [PW-1:0] fifo_out_data;
	logic [NUM_SLOT-1:0] chan_at_high;
	logic reg_left;
	logic chan_left;

	generate
		if (NUM_SLOT != `ACS_NUM_SLOT) begin : g_bad_slots
			$error("acs_sequencer slot count is fixed by the state layout");
		end
		if (FIFO_DEPTH < 2) begin : g_small_fifo
			$error("acs_sequencer result FIFO needs at least two words");
		end
	endgenerate

	// Lowest set flag; used for both registers and channels
	function automatic logic [`ACS_IDX_W-1:0] first_set(
		input logic [`ACS_NUM_SLOT-1:0] v
	);
		logic [`ACS_IDX_W-1:0] r;
		r = '0;
		for (int i = `ACS_NUM_SLOT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = i[`ACS_IDX_W-1:0];
			end
		end
		return r;
	endfunction

	// One-hot mask of a slot; used to retire registers and channels
	function automatic logic [`ACS_NUM_SLOT-1:0] slot_hot(
		input logic [`ACS_IDX_W-1:0] i
	);
		logic [`ACS_NUM_SLOT-1:0] m;
		m = '0;
		m[i] = 1'b1;
		return m;
	endfunction

	// Byte of a per-slot table; the same mux serves three tables
	function automatic logic [`ACS_BYTE_W-1:0] pick_byte(
		input logic [`ACS_NUM_SLOT-1:0][`ACS_BYTE_W-1:0] t,
		input logic [`ACS_IDX_W-1:0] i
	);
		return t[i];
	endfunction

	// Acknowledge from the link counts once stages two and three agree
	assign ack_new = (s.ack_sync[2] == s.ack_sync[1]) &&
		(s.ack_sync[2] != s.ack_seen);
	assign req_new = (l.req_sync[2] == l.req_sync[1]) &&
		(l.req_sync[2] != l.req_seen);

	// The write stage takes a new word when empty or when SRAM accepts
	assign fifo_out_ready = !s.sram_we || sram_ready;

	// Work left; checked when a value byte ends and before each command
	assign reg_left = |s.reg_pend;
	assign chan_left = |s.chan_pend;

	// One comparator per channel; the store state uses the selected one
	generate
		for (genvar g = 0; g < NUM_SLOT; g++) begin : g_chan_end
			assign chan_at_high[g] = (s.ptr == chan_high[g]);
		end
	endgenerate

	acs_fifo #(
		.WIDTH(PW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(s.push),
		.in_ready(fifo_in_ready),
		.in_data(s.push_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// System domain: main sequence and SRAM write stage.
	// Order of work: every enabled register as an index byte and a value
	// byte, then every enabled channel as a command byte and a capture,
	// repeated until its pointer reaches the channel's high address.
	// Each byte is one toggle of req_tog; the link answers with one toggle
	// of ack_tog, so at most one transfer is ever outstanding.
	// Results go through the FIFO so a slow SRAM only stalls capture,
	// never a transfer that is already on the wire.
	always_comb begin
		logic [`ACS_IDX_W-1:0] idx;
		idx = '0;
		next_s = s;
		next_s.push = 1'b0;
		next_s.ack_sync = {s.ack_sync[1:0], l.ack_tog};
		if (ack_new) begin
			next_s.ack_seen = s.ack_sync[2];
		end
		if (s.sram_we && sram_ready) begin
			next_s.sram_we = 1'b0;
		end
		if (fifo_out_valid && fifo_out_ready) begin
			next_s.sram_we = 1'b1;
			next_s.sram_addr = fifo_out_data[PW-1:`ACS_WORD_W];
			next_s.sram_data = fifo_out_data[`ACS_WORD_W-1:0];
		end
		case (s.st)
			acs_st_idle: begin
				next_s.busy = 1'b0;
				next_s.done = 1'b0;
				next_s.req_dir = `ACS_DIR_SEND;
				next_s.req_byte = `ACS_IDLE_BYTE;
				next_s.have = 1'b0;
				next_s.req_last = 1'b0;
				if (start) begin
					next_s.busy = 1'b1;
					next_s.fresh = 1'b1;
					next_s.reg_pend = reg_wr_en;
					next_s.chan_pend = chan_en;
					next_s.st = (|reg_wr_en) ? acs_st_send_index :
						acs_st_send_cmd;
				end
			end
			acs_st_send_index: begin
				idx = first_set(s.reg_pend);
				next_s.reg_sel = idx;
				next_s.reg_pend = s.reg_pend & ~slot_hot(idx);
				next_s.req_byte = pick_byte(reg_index, idx);
				next_s.req_dir = `ACS_DIR_SEND;
				next_s.req_last = 1'b0;
				next_s.req_tog = !s.req_tog;
				next_s.st = acs_st_wait_index;
			end
			acs_st_wait_index: begin
				if (ack_new) begin
					next_s.st = acs_st_send_value;
				end
			end
			acs_st_send_value: begin
				next_s.req_byte = pick_byte(reg_value, s.reg_sel);
				next_s.req_dir = `ACS_DIR_SEND;
				next_s.req_last = 1'b1;
				next_s.req_tog = !s.req_tog;
				next_s.st = acs_st_wait_value;
			end
			acs_st_wait_value: begin
				if (ack_new) begin
					next_s.st = reg_left ? acs_st_send_index :
						acs_st_send_cmd;
				end
			end
			acs_st_send_cmd: begin
				// Same command again until the channel's high address is stored
				if (!chan_left) begin
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
					next_s.st = acs_st_done;
				end else begin
					idx = first_set(s.chan_pend);
					next_s.chan_sel = idx;
					// A new channel starts at its base, a repeat steps on
					next_s.ptr = s.fresh ? chan_base[idx] :
						s.ptr + `ACS_PTR_STEP;
					next_s.fresh = 1'b0;
					next_s.req_byte = pick_byte(chan_cmd, idx);
					next_s.req_dir = `ACS_DIR_SEND;
					next_s.req_last = 1'b0;
					next_s.req_tog = !s.req_tog;
					next_s.st = acs_st_await_cmd_sent;
				end
			end
			acs_st_await_cmd_sent: begin
				if (ack_new) begin
					next_s.st = acs_st_start_capture;
				end
			end
			acs_st_start_capture: begin
				// A dummy byte; the shifter only clocks in during a receive
				next_s.req_byte = `ACS_IDLE_BYTE;
				next_s.req_dir = `ACS_DIR_RECV;
				next_s.req_last = 1'b1;
				next_s.req_tog = !s.req_tog;
				next_s.st = acs_st_store;
			end
			acs_st_store: begin
				// Remember an answer that arrives while the FIFO is full
				if (ack_new) begin
					next_s.have = 1'b1;
				end
				// A full FIFO holds the sequence here until SRAM drains it
				if ((s.have || ack_new) && fifo_in_ready) begin
					next_s.have = 1'b0;
					next_s.push = 1'b1;
					next_s.push_data = {s.ptr, l.rx};
					if (chan_at_high[s.chan_sel]) begin
						next_s.chan_pend = s.chan_pend &
							~slot_hot(s.chan_sel);
						next_s.fresh = 1'b1;
					end
					next_s.st = acs_st_send_cmd;
				end
			end
			acs_st_done: begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.push = 1'b0;
				next_s.req_tog = s.req_tog;
			end
			default: begin
				next_s.st = acs_st_idle;
			end
		endcase
	end

	// State of the system domain, reset to idle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s <= SYS_RST;
		end else begin
			s <= next_s;
		end
	end

	// Link domain: request handshake, shift start and chip select.
	// The payload fields of s are only read in the cycle that sees a new
	// request; the system side leaves them alone until the answer, so no
	// bit of them can be caught mid-change.
	// Chip select is raised only after the last byte of a command, and the
	// round trip through both synchronisers keeps it high for a few link
	// cycles before the next command pulls it low.
	always_comb begin
		next_l = l;
		next_l.req_sync = {l.req_sync[1:0], s.req_tog};
		case (l.st)
			acs_ln_idle: begin
				next_l.go = 1'b0;
				if (req_new) begin
					// Payload was frozen by the system side in the same cycle as the toggle
					next_l.req_seen = l.req_sync[2];
					next_l.tx = s.req_byte;
					next_l.dir = s.req_dir;
					next_l.last = s.req_last;
					next_l.cs_n = 1'b0;
					next_l.st = acs_ln_arm;
				end
			end
			acs_ln_arm: begin
				// A stale done flag must clear before a new rising edge
				if (!shift_done) begin
					next_l.go = 1'b1;
					next_l.st = acs_ln_busy;
				end
			end
			acs_ln_busy: begin
				if (shift_done) begin
					next_l.go = 1'b0;
					if (l.dir == `ACS_DIR_RECV) begin
						next_l.rx = shift_rx;
					end
					if (l.last) begin
						next_l.cs_n = 1'b1;
					end
					next_l.ack_tog = !l.ack_tog;
					next_l.st = acs_ln_idle;
				end
			end
			default: begin
				next_l.st = acs_ln_idle;
			end
		endcase
	end

	always_ff @(posedge clk_link or negedge nrst) begin
		if (!nrst) begin
			l <= LINK_RST;
		end else begin
			l <= next_l;
		end
	end

	// Every output is a register of one of the two domains
	assign busy = s.busy;
	assign done = s.done;
	assign sram_we = s.sram_we;
	assign sram_addr = s.sram_addr;
	assign sram_data = s.sram_data;
	assign shift_go = l.go;
	assign shift_dir = l.dir;
	assign shift_tx = l.tx;
	assign adc_cs_n = l.cs_n;
endmodule // acs_sequencer
`default_nettype wire
